// [verilog/stl_pkg.sv]
// constants shared by the torque limit selector and its testbench
package stl_pkg;

	// ---------------------------------------------------------------
	// register offsets (word index on the plain register port)
	// ---------------------------------------------------------------
	localparam logic [3:0] REG_GAIN = 4'h0; // analog_torque_gain
	localparam logic [3:0] REG_FWD_INT = 4'h1; // forward_internal_limit
	localparam logic [3:0] REG_REV_INT = 4'h2; // reverse_internal_limit
	localparam logic [3:0] REG_FWD_EXT = 4'h3; // forward_external_limit
	localparam logic [3:0] REG_REV_EXT = 4'h4; // reverse_external_limit
	localparam logic [3:0] REG_FILT = 4'h5; // analog_limit_filter_time
	localparam logic [3:0] REG_SELECT = 4'h6; // analog_limit_select, pending
	localparam logic [3:0] REG_MOTOR_MAX = 4'h7; // motor maximum torque
	localparam logic [3:0] REG_STATUS = 4'h8; // live status, read only
	localparam logic [3:0] REG_EFF_FWD = 4'h9; // effective forward limit
	localparam logic [3:0] REG_EFF_REV = 4'hA; // effective reverse limit

	// ---------------------------------------------------------------
	// reset values
	// ---------------------------------------------------------------
	localparam logic [15:0] RST_GAIN = 16'h001E; // rated torque at 3.0 V
	localparam logic [15:0] RST_INT_LIMIT = 16'h0320; // 800 percent
	localparam logic [15:0] RST_EXT_LIMIT = 16'h0064; // 100 percent
	localparam logic [15:0] RST_FILT = 16'h0000; // no filtering
	localparam logic [15:0] RST_MOTOR_MAX = 16'h012C; // 300 percent
	localparam logic [3:0] RST_SELECT = 4'h0; // analog limit off

	// ---------------------------------------------------------------
	// field layout and encodings
	// ---------------------------------------------------------------
	localparam logic [15:0] GAIN_MIN = 16'h000A; // 1.0 V floor
	localparam logic [3:0] SEL_NONE = 4'h0; // internal and external only
	localparam logic [3:0] SEL_ANALOG = 4'h1; // analog limit outside torque control
	localparam logic [3:0] SEL_COMBINED = 4'h3; // analog with external request
	localparam logic [1:0] MODE_SPEED = 2'h0; // speed control
	localparam logic [1:0] MODE_POSITION = 2'h1; // position control
	localparam logic [1:0] MODE_TORQUE = 2'h2; // torque control
	localparam int STS_FLAG = 0; // torque limiting flag bit
	localparam int STS_FWD_REQ = 1; // forward request seen
	localparam int STS_REV_REQ = 2; // reverse request seen
	localparam int STS_ANALOG = 3; // analog limit in use

	// ---------------------------------------------------------------
	// timing
	// ---------------------------------------------------------------
	localparam int CLK_PERIOD_PS = 25000; // 40 MHz clock
	localparam int FILT_STEP_PS = 10000000; // filter unit, 0.01 ms
	localparam int FILT_STEP_CYC = FILT_STEP_PS / CLK_PERIOD_PS; // 400
	localparam int EXT_STAGES = 2; // request sampling depth

endpackage : stl_pkg

// [verilog/stl_lpf.sv]
// first-order low-pass filter for the analog limit voltage
`timescale 1ns/1ps
`default_nettype none

module stl_lpf #(
	parameter int W = 16, // sample width
	parameter int FW = 16 // fraction bits of the accumulator
) (
	input wire logic clk, // system clock
	input wire logic rst_b, // async reset, active low
	input wire logic step, // one pulse per time-constant unit
	input wire logic [15:0] tau, // time constant in steps, 0 bypasses
	input wire logic signed [W-1:0] x, // raw sample
	output logic signed [W-1:0] y // filtered sample
);

	// ---------------------------------------------------------------
	// state
	// ---------------------------------------------------------------
	typedef struct packed {
		logic signed [W+FW-1:0] acc; // filter output with fraction
	} stl_lpf_t;

	stl_lpf_t q; // registered state
	stl_lpf_t next_q; // next state
	logic signed [W+FW:0] diff; // input minus output, scaled
	logic signed [W+FW:0] delta; // correction for one step

	// ---------------------------------------------------------------
	// next state
	// ---------------------------------------------------------------
	// each step moves the output by diff / tau toward the input
	always_comb
	begin
		next_q = q;
		diff = $signed({x[W-1], x, {FW{1'b0}}}) - $signed({q.acc[W+FW-1], q.acc});
		delta = diff / $signed({{(W+FW+1-16){1'b0}}, tau});
		if (tau == 16'h0000)
		begin
			next_q.acc = $signed({x, {FW{1'b0}}}); // bypass
		end
		else if (step)
		begin
			next_q.acc = q.acc + delta[W+FW-1:0]; // one filter step
		end
	end

	// register the state
	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
			q <= '0;
		else
			q <= next_q;
	end

	assign y = q.acc[W+FW-1:FW];

	a_filter_bypass: assert property (@(posedge clk) disable iff (!rst_b)
		(tau == 16'h0000) |=> (y == $past(x)))
		else $error("filter with zero time constant did not pass input");

endmodule : stl_lpf

`default_nettype wire

// [verilog/stl_selector.sv]
// torque limit selector: internal, external and analog limits
//
// The implementer's own choices: the placing of the registers and the strobed register port.
`timescale 1ns/1ps
`default_nettype none

// Overview of operation
// - always cap torque at internal limits
// - clamp every limit to motor maximum torque
// - forward request closed: min internal, external
// - forward request open: internal limit only
// - reverse request closed: min internal, external
// - reverse request open: internal limit only
// - select 1 uses analog, after restart
// - analog mode: min analog and internal
// - analog limit only in speed, position
// - analog magnitude limits both directions equally
// - gain gives volts for rated torque
// - first-order analog filter, zero bypasses
// - select 3: min of three with request
// - request change seen within 2 ms
// - flag high while torque held at limit
module stl_selector #(
	parameter int W = 16 // torque and voltage sample width
) (
	input wire logic clk, // system clock, 40 MHz
	input wire logic rst_b, // async reset, active low
	input wire logic [3:0] addr, // register index
	input wire logic [15:0] wr_data, // register write data
	input wire logic wr_en, // write strobe
	input wire logic rd_en, // read strobe
	output logic [15:0] rd_data, // read data, cycle after strobe
	input wire logic restart, // restart pulse, loads selection
	input wire logic fwd_ext_limit_req, // forward request, high closed
	input wire logic rev_ext_limit_req, // reverse request, high closed
	input wire logic [1:0] ctrl_mode, // speed, position or torque
	input wire logic signed [W-1:0] analog_ref, // analog input in mV
	input wire logic signed [W-1:0] torque_cmd, // torque command, percent
	output logic signed [W-1:0] torque_out, // limited torque
	output logic torque_limiting_flag, // torque held at a limit
	output logic [15:0] eff_fwd_limit, // effective forward limit
	output logic [15:0] eff_rev_limit // effective reverse limit
);

	// ---------------------------------------------------------------
	// state
	// ---------------------------------------------------------------
	// depth of the request sampling chain, sizes the state fields below
	localparam int EXT_STAGES = stl_pkg::EXT_STAGES; // request depth

	typedef struct packed {
		logic [15:0] gain; // volts per rated torque, 0.1 V
		logic [15:0] fwd_int; // forward internal limit
		logic [15:0] rev_int; // reverse internal limit
		logic [15:0] fwd_ext; // forward external limit
		logic [15:0] rev_ext; // reverse external limit
		logic [15:0] filt_tau; // filter time constant
		logic [15:0] motor_max; // motor maximum torque
		logic [3:0] sel_pend; // selection written by software
		logic [3:0] sel_act; // selection in force since restart
		logic [EXT_STAGES-1:0] fwd_req; // sampled forward request
		logic [EXT_STAGES-1:0] rev_req; // sampled reverse request
		logic [8:0] tick_cnt; // filter step divider
		logic tick; // filter step pulse
		logic [15:0] rd_data; // read answer
		logic [15:0] eff_fwd; // effective forward limit
		logic [15:0] eff_rev; // effective reverse limit
		logic signed [W-1:0] torque_out; // saturated command
		logic flag; // torque limiting flag
	} stl_sel_t;

	stl_sel_t q; // registered state
	stl_sel_t next_q; // next state
	logic signed [W-1:0] filt_ref; // filtered analog voltage
	logic [W-1:0] ref_mag; // magnitude of the analog voltage
	logic [15:0] gain_eff; // gain with floor applied
	logic [15:0] analog_lim; // analog limit in percent
	logic analog_on; // analog limit applies now
	logic fwd_on; // forward request active
	logic rev_on; // reverse request active
	logic [15:0] base_fwd; // forward limit without analog
	logic [15:0] base_rev; // reverse limit without analog
	logic signed [W:0] cmd_x; // command widened
	logic signed [W:0] lim_f; // forward limit, signed
	logic signed [W:0] lim_r; // reverse limit, negated

	// smaller of two limits
	function automatic logic [15:0] stl_min(input logic [15:0] a, input logic [15:0] b);
		stl_min = (a < b) ? a : b;
	endfunction : stl_min

	// ---------------------------------------------------------------
	// analog filter
	// ---------------------------------------------------------------
	stl_lpf #(
		.W(W),
		.FW(16)
	) u_lpf (
		.clk(clk),
		.rst_b(rst_b),
		.step(q.tick),
		.tau(q.filt_tau),
		.x(analog_ref),
		.y(filt_ref)
	);

	// ---------------------------------------------------------------
	// limit selection
	// ---------------------------------------------------------------
	// all limits recomputed from current settings every cycle
	always_comb
	begin
		fwd_on = q.fwd_req[EXT_STAGES-1];
		rev_on = q.rev_req[EXT_STAGES-1];
		// sign dropped, magnitude scaled by gain
		ref_mag = filt_ref[W-1] ? W'(-filt_ref) : W'(filt_ref);
		gain_eff = (q.gain < stl_pkg::GAIN_MIN) ? stl_pkg::GAIN_MIN : q.gain;
		analog_lim = 16'(ref_mag / gain_eff);
		// no analog limiting in torque control
		analog_on = (ctrl_mode != stl_pkg::MODE_TORQUE) && (q.sel_act == stl_pkg::SEL_ANALOG
			|| q.sel_act == stl_pkg::SEL_COMBINED);
		// internal limit always, each capped at motor max
		base_fwd = stl_min(q.fwd_int, q.motor_max);
		base_rev = stl_min(q.rev_int, q.motor_max);
		// external request adds its own limit
		if (fwd_on)
			base_fwd = stl_min(base_fwd, q.fwd_ext);
		if (rev_on)
			base_rev = stl_min(base_rev, q.rev_ext);
		next_q = q;
		next_q.eff_fwd = base_fwd;
		next_q.eff_rev = base_rev;
		if (analog_on && q.sel_act == stl_pkg::SEL_ANALOG)
		begin
			// analog limit in both directions
			next_q.eff_fwd = stl_min(base_fwd, analog_lim);
			next_q.eff_rev = stl_min(base_rev, analog_lim);
		end
		else if (analog_on)
		begin
			// combined mode: analog only under a request
			if (fwd_on)
				next_q.eff_fwd = stl_min(base_fwd, analog_lim);
			if (rev_on)
				next_q.eff_rev = stl_min(base_rev, analog_lim);
		end

		// saturate the command with the new limits
		cmd_x = {torque_cmd[W-1], torque_cmd};
		lim_f = $signed({1'b0, next_q.eff_fwd[W-1:0]});
		lim_r = -$signed({1'b0, next_q.eff_rev[W-1:0]});
		if (cmd_x > lim_f)
		begin
			next_q.torque_out = lim_f[W-1:0];
			next_q.flag = 1'b1; // held at forward limit
		end
		else if (cmd_x < lim_r)
		begin
			next_q.torque_out = lim_r[W-1:0];
			next_q.flag = 1'b1; // held at reverse limit
		end
		else
		begin
			next_q.torque_out = torque_cmd;
			next_q.flag = 1'b0;
		end

		// sample the request pins, two cycles well inside 2 ms
		next_q.fwd_req = {q.fwd_req[EXT_STAGES-2:0], fwd_ext_limit_req};
		next_q.rev_req = {q.rev_req[EXT_STAGES-2:0], rev_ext_limit_req};

		// filter step divider, one pulse each 0.01 ms
		if (q.tick_cnt == 9'(stl_pkg::FILT_STEP_CYC - 1))
		begin
			next_q.tick_cnt = 9'h000;
			next_q.tick = 1'b1;
		end
		else
		begin
			next_q.tick_cnt = q.tick_cnt + 9'h001;
			next_q.tick = 1'b0;
		end

		// selection only taken over at restart
		if (restart)
			next_q.sel_act = q.sel_pend;

		// register writes, effective next cycle
		if (wr_en)
		begin
			if (addr == stl_pkg::REG_GAIN)
				next_q.gain = wr_data;
			else if (addr == stl_pkg::REG_FWD_INT)
				next_q.fwd_int = wr_data;
			else if (addr == stl_pkg::REG_REV_INT)
				next_q.rev_int = wr_data;
			else if (addr == stl_pkg::REG_FWD_EXT)
				next_q.fwd_ext = wr_data;
			else if (addr == stl_pkg::REG_REV_EXT)
				next_q.rev_ext = wr_data;
			else if (addr == stl_pkg::REG_FILT)
				next_q.filt_tau = wr_data;
			else if (addr == stl_pkg::REG_SELECT)
				next_q.sel_pend = wr_data[3:0];
			else if (addr == stl_pkg::REG_MOTOR_MAX)
				next_q.motor_max = wr_data;
		end

		// register reads, answer stands one cycle only
		next_q.rd_data = 16'h0000;
		if (rd_en)
		begin
			if (addr == stl_pkg::REG_GAIN)
				next_q.rd_data = q.gain;
			else if (addr == stl_pkg::REG_FWD_INT)
				next_q.rd_data = q.fwd_int;
			else if (addr == stl_pkg::REG_REV_INT)
				next_q.rd_data = q.rev_int;
			else if (addr == stl_pkg::REG_FWD_EXT)
				next_q.rd_data = q.fwd_ext;
			else if (addr == stl_pkg::REG_REV_EXT)
				next_q.rd_data = q.rev_ext;
			else if (addr == stl_pkg::REG_FILT)
				next_q.rd_data = q.filt_tau;
			else if (addr == stl_pkg::REG_SELECT)
				next_q.rd_data = {8'h00, q.sel_act, q.sel_pend};
			else if (addr == stl_pkg::REG_MOTOR_MAX)
				next_q.rd_data = q.motor_max;
			else if (addr == stl_pkg::REG_STATUS)
			begin
				next_q.rd_data[stl_pkg::STS_FLAG] = q.flag;
				next_q.rd_data[stl_pkg::STS_FWD_REQ] = fwd_on;
				next_q.rd_data[stl_pkg::STS_REV_REQ] = rev_on;
				next_q.rd_data[stl_pkg::STS_ANALOG] = analog_on;
			end
			else if (addr == stl_pkg::REG_EFF_FWD)
				next_q.rd_data = q.eff_fwd;
			else if (addr == stl_pkg::REG_EFF_REV)
				next_q.rd_data = q.eff_rev;
		end
	end

	// ---------------------------------------------------------------
	// state register
	// ---------------------------------------------------------------
	// reset loads the documented defaults
	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			q <= '0;
			q.gain <= stl_pkg::RST_GAIN;
			q.fwd_int <= stl_pkg::RST_INT_LIMIT;
			q.rev_int <= stl_pkg::RST_INT_LIMIT;
			q.fwd_ext <= stl_pkg::RST_EXT_LIMIT;
			q.rev_ext <= stl_pkg::RST_EXT_LIMIT;
			q.filt_tau <= stl_pkg::RST_FILT;
			q.motor_max <= stl_pkg::RST_MOTOR_MAX;
			q.sel_pend <= stl_pkg::RST_SELECT;
			q.sel_act <= stl_pkg::RST_SELECT;
		end
		else
		begin
			q <= next_q;
		end
	end

	// outputs straight from flip-flops
	assign rd_data = q.rd_data;
	assign torque_out = q.torque_out;
	assign torque_limiting_flag = q.flag;
	assign eff_fwd_limit = q.eff_fwd;
	assign eff_rev_limit = q.eff_rev;

	// ---------------------------------------------------------------
	// checks
	// ---------------------------------------------------------------
	a_fwd_int_cap: assert property (@(posedge clk) disable iff (!rst_b)
		##1 (q.eff_fwd <= $past(q.fwd_int) && q.eff_rev <= $past(q.rev_int)))
		else $error("effective limit above internal limit");

	a_motor_max_cap: assert property (@(posedge clk) disable iff (!rst_b)
		##1 (q.eff_fwd <= $past(q.motor_max) && q.eff_rev <= $past(q.motor_max)))
		else $error("effective limit above motor maximum");

	a_fwd_ext_min: assert property (@(posedge clk) disable iff (!rst_b)
		fwd_on |=> (q.eff_fwd <= $past(q.fwd_ext)))
		else $error("forward external limit not applied");

	a_fwd_open_int: assert property (@(posedge clk) disable iff (!rst_b)
		(!fwd_on && !analog_on) |=> (q.eff_fwd == $past(stl_min(q.fwd_int, q.motor_max))))
		else $error("forward limit not internal when request open");

	a_rev_ext_min: assert property (@(posedge clk) disable iff (!rst_b)
		rev_on |=> (q.eff_rev <= $past(q.rev_ext)))
		else $error("reverse external limit not applied");

	a_rev_open_int: assert property (@(posedge clk) disable iff (!rst_b)
		(!rev_on && !analog_on) |=> (q.eff_rev == $past(stl_min(q.rev_int, q.motor_max))))
		else $error("reverse limit not internal when request open");

	a_sel_restart: assert property (@(posedge clk) disable iff (!rst_b)
		!restart |=> (q.sel_act == $past(q.sel_act)))
		else $error("selection changed without restart");

	a_analog_both: assert property (@(posedge clk) disable iff (!rst_b)
		(analog_on && q.sel_act == stl_pkg::SEL_ANALOG)
		|=> (q.eff_fwd <= $past(analog_lim) && q.eff_rev <= $past(analog_lim)))
		else $error("analog limit not applied to both directions");

	a_torque_no_analog: assert property (@(posedge clk) disable iff (!rst_b)
		(ctrl_mode == stl_pkg::MODE_TORQUE) |=> (q.eff_fwd == $past(base_fwd)))
		else $error("analog limit used in torque control");

	a_ext_latency: assert property (@(posedge clk) disable iff (!rst_b)
		##2 (fwd_on == $past(fwd_ext_limit_req, 2)))
		else $error("forward request not seen after two cycles");

	a_flag_hold: assert property (@(posedge clk) disable iff (!rst_b)
		q.flag |-> (q.torque_out == W'(q.eff_fwd) || q.torque_out == -W'(q.eff_rev)))
		else $error("flag set while torque not at a limit");

	a_sat_bound: assert property (@(posedge clk) disable iff (!rst_b)
		##1 ($signed({q.torque_out[W-1], q.torque_out}) <= $signed({1'b0, q.eff_fwd[W-1:0]})))
		else $error("torque above forward limit");

	a_write_next: assert property (@(posedge clk) disable iff (!rst_b)
		(wr_en && addr == stl_pkg::REG_FWD_INT) |=> (q.fwd_int == $past(wr_data)))
		else $error("limit write not effective next cycle");

	a_analog_sym: assert property (@(posedge clk) disable iff (!rst_b)
		(analog_on && q.sel_act == stl_pkg::SEL_ANALOG && analog_lim <= base_fwd && analog_lim <= base_rev)
		|=> (q.eff_fwd == q.eff_rev))
		else $error("analog limit differs between directions");

	a_combined_fwd: assert property (@(posedge clk) disable iff (!rst_b)
		(analog_on && q.sel_act == stl_pkg::SEL_COMBINED && fwd_on)
		|=> (q.eff_fwd == $past(stl_min(base_fwd, analog_lim))))
		else $error("combined forward limit not smallest of three");

	a_combined_rev: assert property (@(posedge clk) disable iff (!rst_b)
		(analog_on && q.sel_act == stl_pkg::SEL_COMBINED && rev_on)
		|=> (q.eff_rev == $past(stl_min(base_rev, analog_lim))))
		else $error("combined reverse limit not smallest of three");

endmodule : stl_selector

`default_nettype wire

// [tb/stl_host_model.sv]
// host controller model that drives the external limit request contacts
`timescale 1ns/1ps
`default_nettype none

module stl_host_model (
	input wire logic clk, // system clock
	input wire logic rst_b, // async reset, active low
	input wire logic want_fwd, // bench wants reduced forward torque
	input wire logic want_rev, // bench wants reduced reverse torque
	input wire logic slow, // act one cycle later
	output logic fwd_ext_limit_req, // forward request, high closed
	output logic rev_ext_limit_req // reverse request, high closed
);
	logic [1:0] lag; // wishes seen one cycle ago

	// contacts follow the wish right after an edge, a cycle later when slow
	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			lag <= 2'h0;
			fwd_ext_limit_req <= 1'b0;
			rev_ext_limit_req <= 1'b0;
		end
		else
		begin
			lag <= {want_rev, want_fwd};
			fwd_ext_limit_req <= slow ? lag[0] : want_fwd;
			rev_ext_limit_req <= slow ? lag[1] : want_rev;
		end
	end
endmodule : stl_host_model
`default_nettype wire

// [tb/tb_top.sv]
// self-checking bench for the torque limit selector
`timescale 1ns/1ps
`default_nettype none

module tb_top;
	typedef struct {
		logic f; // forward wish
		logic r; // reverse wish
		logic [15:0] cmd; // torque command
		logic [15:0] ef; // expected forward limit
		logic [15:0] er; // expected reverse limit
		logic [15:0] out; // expected torque
		logic flag; // expected limiting flag
	} stl_row_t;

	logic clk = 1'b0; // 40 MHz clock
	logic rst_b = 1'b0; // reset, active low
	logic [3:0] addr = 4'h0; // register index
	logic [15:0] wr_data = 16'h0000; // write data
	logic wr_en = 1'b0; // write strobe
	logic rd_en = 1'b0; // read strobe
	logic restart = 1'b0; // selection load pulse
	logic want_fwd = 1'b0; // forward wish to host
	logic want_rev = 1'b0; // reverse wish to host
	logic slow = 1'b0; // slow host answers
	logic [1:0] ctrl_mode = 2'h0; // control mode
	logic signed [15:0] analog_ref = 16'sh0000; // analog limit voltage
	logic signed [15:0] torque_cmd = 16'sh0000; // torque command
	wire logic [15:0] rd_data; // read answer
	wire logic fwd_req; // forward contact
	wire logic rev_req; // reverse contact
	wire logic signed [15:0] torque_out; // limited torque
	wire logic flag; // limiting flag
	wire logic [15:0] eff_fwd; // effective forward limit
	wire logic [15:0] eff_rev; // effective reverse limit
	int n_fail = 0; // mismatches
	int checks_done = 0; // comparisons
	int cyc = 0; // cycle counter for the hang guard
	logic [15:0] v; // read value
	stl_row_t rows [7]; // ordinary cases
	logic [15:0] rst_tab [8]; // register reset values

	stl_selector stl_selector_i (.clk(clk), .rst_b(rst_b), .addr(addr), .wr_data(wr_data), .wr_en(wr_en),
		.rd_en(rd_en), .rd_data(rd_data), .restart(restart), .fwd_ext_limit_req(fwd_req),
		.rev_ext_limit_req(rev_req), .ctrl_mode(ctrl_mode), .analog_ref(analog_ref), .torque_cmd(torque_cmd),
		.torque_out(torque_out), .torque_limiting_flag(flag), .eff_fwd_limit(eff_fwd), .eff_rev_limit(eff_rev));
	stl_host_model stl_host_model_i (.clk(clk), .rst_b(rst_b), .want_fwd(want_fwd), .want_rev(want_rev),
		.slow(slow), .fwd_ext_limit_req(fwd_req), .rev_ext_limit_req(rev_req));

	// clock, 25 ns period
	initial
	begin
		forever #12.5 clk = ~clk;
	end

	// hang guard
	always @(posedge clk)
	begin
		cyc <= cyc + 1;
		if (cyc == 30000)
		begin
			n_fail++;
			test_done();
		end
	end

	// counts, verdict and end of run
	task automatic test_done();
		$display("checks %0d mismatches %0d", checks_done, n_fail);
		if (n_fail == 0 && checks_done > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask : test_done

	// one register write
	task automatic wr(input logic [3:0] a, input logic [15:0] d);
		@(posedge clk);
		addr <= a;
		wr_data <= d;
		wr_en <= 1'b1;
		@(posedge clk);
		wr_en <= 1'b0;
	endtask : wr

	// one register read, answer taken in the following cycle
	task automatic rd(input logic [3:0] a, output logic [15:0] d);
		@(posedge clk);
		addr <= a;
		rd_en <= 1'b1;
		@(posedge clk);
		rd_en <= 1'b0;
		#1 d = rd_data;
	endtask : rd

	// compare and count
	task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
		checks_done++;
		if (got !== exp)
		begin
			n_fail++;
			$display("ERROR %0t %s got %h exp %h", $time, what, got, exp);
		end
	endtask : chk

	// let the limit path settle
	task automatic settle(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask : settle

	// limits in both directions
	task automatic lims(input logic [15:0] f, input logic [15:0] r, input string what);
		chk(eff_fwd, f, what);
		chk(eff_rev, r, what);
	endtask : lims

	// load the pending selection
	task automatic pulse_restart();
		@(posedge clk);
		restart <= 1'b1;
		@(posedge clk);
		restart <= 1'b0;
	endtask : pulse_restart

	// main sequence
	initial
	begin
		rows = '{'{0, 0, 16'h0064, 16'h00C8, 16'h00FA, 16'h0064, 0}, '{0, 0, 16'h01F4, 16'h00C8, 16'h00FA, 16'h00C8, 1},
			'{0, 0, 16'hFE0C, 16'h00C8, 16'h00FA, 16'hFF06, 1}, '{1, 0, 16'h01F4, 16'h0096, 16'h00FA, 16'h0096, 1},
			'{0, 1, 16'hFE0C, 16'h00C8, 16'h0078, 16'hFF88, 1}, '{1, 1, 16'h00C8, 16'h0096, 16'h0078, 16'h0096, 1},
			'{0, 0, 16'h00C8, 16'h00C8, 16'h00FA, 16'h00C8, 0}};
		rst_tab = '{stl_pkg::RST_GAIN, stl_pkg::RST_INT_LIMIT, stl_pkg::RST_INT_LIMIT, stl_pkg::RST_EXT_LIMIT,
			stl_pkg::RST_EXT_LIMIT, stl_pkg::RST_FILT, 16'h0000, stl_pkg::RST_MOTOR_MAX};
		repeat (5) @(posedge clk);
		rst_b <= 1'b1;
		settle(2);
		lims(16'h012C, 16'h012C, "reset limits");
		for (int i = 0; i < 8; i++)
		begin
			rd(4'(i), v);
			chk(v, rst_tab[i], "reset value");
		end
		rd(4'hB, v);
		chk(v, 16'h0000, "unmapped read");
		$display("test reset done");
		wr(stl_pkg::REG_FWD_INT, 16'h00C8);
		rd(stl_pkg::REG_FWD_INT, v);
		chk(v, 16'h00C8, "write back");
		wr(stl_pkg::REG_REV_INT, 16'h00FA);
		wr(stl_pkg::REG_FWD_EXT, 16'h0096);
		wr(stl_pkg::REG_REV_EXT, 16'h0078);
		wr(stl_pkg::REG_STATUS, 16'hFFFF);
		foreach (rows[i])
		begin
			@(posedge clk);
			want_fwd <= rows[i].f;
			want_rev <= rows[i].r;
			slow <= 1'(i % 2);
			torque_cmd <= rows[i].cmd;
			settle(7);
			lims(rows[i].ef, rows[i].er, "row limits");
			chk(torque_out, rows[i].out, "row torque");
			chk({15'h0000, flag}, {15'h0000, rows[i].flag}, "row flag");
		end
		rd(stl_pkg::REG_EFF_FWD, v);
		chk(v, 16'h00C8, "eff read");
		$display("test table done");
		wr(stl_pkg::REG_MOTOR_MAX, 16'h0078);
		settle(4);
		lims(16'h0078, 16'h0078, "motor max");
		wr(stl_pkg::REG_MOTOR_MAX, 16'h012C);
		analog_ref <= 16'sh05DC;
		wr(stl_pkg::REG_SELECT, 16'h0001);
		settle(6);
		lims(16'h00C8, 16'h00FA, "select pending");
		pulse_restart();
		settle(6);
		lims(16'h0032, 16'h0032, "analog limit");
		@(posedge clk);
		analog_ref <= -16'sh05DC;
		settle(6);
		lims(16'h0032, 16'h0032, "analog sign");
		wr(stl_pkg::REG_GAIN, 16'h003C);
		settle(6);
		lims(16'h0019, 16'h0019, "analog gain");
		@(posedge clk);
		ctrl_mode <= stl_pkg::MODE_POSITION;
		settle(6);
		lims(16'h0019, 16'h0019, "position mode");
		@(posedge clk);
		ctrl_mode <= stl_pkg::MODE_TORQUE;
		settle(6);
		lims(16'h00C8, 16'h00FA, "torque mode");
		@(posedge clk);
		ctrl_mode <= stl_pkg::MODE_SPEED;
		$display("test analog done");
		wr(stl_pkg::REG_GAIN, 16'h001E);
		analog_ref <= 16'sh0BB8;
		wr(stl_pkg::REG_SELECT, 16'h0003);
		pulse_restart();
		want_fwd <= 1'b1;
		settle(7);
		lims(16'h0064, 16'h00FA, "combined");
		rd(stl_pkg::REG_STATUS, v);
		chk(v, 16'h000B, "status flags");
		rd(stl_pkg::REG_EFF_REV, v);
		chk(v, 16'h00FA, "eff rev read");
		@(posedge clk);
		want_fwd <= 1'b0;
		settle(7);
		lims(16'h00C8, 16'h00FA, "combined open");
		$display("test combined done");
		wr(stl_pkg::REG_SELECT, 16'h0001);
		pulse_restart();
		analog_ref <= 16'sh0000;
		settle(6);
		lims(16'h0000, 16'h0000, "zero analog");
		wr(stl_pkg::REG_FILT, 16'h0002);
		analog_ref <= 16'sh0BB8;
		settle(6);
		checks_done++;
		if (eff_fwd >= 16'h0064 || $isunknown(eff_fwd))
		begin
			n_fail++;
			$display("ERROR %0t filter passed step at once", $time);
		end
		settle(25 * stl_pkg::FILT_STEP_CYC);
		checks_done++;
		if (!(eff_fwd inside {16'h0063, 16'h0064}))
		begin
			n_fail++;
			$display("ERROR %0t filter did not settle %h", $time, eff_fwd);
		end
		$display("test filter done");
		@(posedge clk);
		rst_b <= 1'b0;
		repeat (2) @(posedge clk);
		rst_b <= 1'b1;
		rd(stl_pkg::REG_FWD_INT, v);
		chk(v, stl_pkg::RST_INT_LIMIT, "second reset");
		rd(stl_pkg::REG_SELECT, v);
		chk(v, 16'h0000, "second reset select");
		$display("test second reset done");
		test_done();
	end
endmodule : tb_top
`default_nettype wire
